//--- ltp_pkg.sv
// Shared constants, register map and carrier types of the test pattern and calibration block
package ltp_pkg;
	localparam int LANES = 12;
	localparam int BUSES = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int PAT_LEN = 8;
	localparam int IDX_W = 3;
	localparam int CNT_W = 16;

	// Register byte addresses
	localparam logic [7:0] ADDR_LINK_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PATTERN_SELECT_REG = 8'h04;
	localparam logic [7:0] ADDR_USER_PATTERN_CONTROL_REG = 8'h08;
	localparam logic [7:0] ADDR_DEV_CFG = 8'h0C;
	localparam logic [7:0] ADDR_CAL_CFG = 8'h10;
	localparam logic [7:0] ADDR_CALIBRATION_TRIGGER_PIN = 8'h14;
	localparam logic [7:0] ADDR_CAL_STAT = 8'h18;
	localparam logic [7:0] ADDR_TRIM_I = 8'h1C;
	localparam logic [7:0] ADDR_TRIM_Q = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
	localparam logic [7:0] ADDR_UPAT_BASE = 8'h40;
	localparam logic [7:0] ADDR_UPAT_LAST = 8'h5C;

	// Field positions
	localparam int LINK_SRC_BIT = 0;
	localparam int LINK_SWSEL_BIT = 1;
	localparam int PAT_ACT_BIT = 0;
	localparam int PAT_SYNC_LO = 2;
	localparam int UPAT_LANE_BIT = 4;
	localparam int CFG_PD_BIT = 0;
	localparam int OFFSET_CALIBRATION_ENABLE_BIT = 0;
	localparam int CAL_SRC_BIT = 1;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int IRQ_CAL_BIT = 0;
	localparam int IRQ_PDX_BIT = 1;
	localparam int INV_BASE_BIT = 8;

	// Reset values and fixed codes
	localparam logic [11:0] MID_CODE = 12'h000;
	localparam logic [11:0] TRIM_RESET = 12'h000;
	localparam logic [7:0] FIXED_LANE_PATTERN_ENABLE_MASK = 8'hE2;

	typedef logic [BUSES-1:0][LANES-1:0] ltp_quad_t;

	typedef enum logic [1:0] {
		LTP_SYNC_USER,
		LTP_SYNC_STROBE_LSB,
		LTP_SYNC_STROBE_ALL,
		LTP_SYNC_SPARE
	} ltp_sync_pattern_select_e;

	typedef struct packed {
		logic sync_from_reg;
		logic act_user;
		ltp_sync_pattern_select_e sync_pattern_select;
		logic fixed_lane_pattern_enable;
	} ltp_frame_cfg_s;

	typedef struct packed {
		ltp_quad_t data;
		logic strobe;
	} ltp_out_s;
endpackage : ltp_pkg

//--- ltp_top.sv
// Output pattern selection, power-down gating and foreground calibration control
//
// Behaviour
// R1 - Active and sync patterns held; toggling source is pin by default, else register
// R2 - Switching between active and sync patterns only on strobe falling edge
// R3 - Active pattern selects converted samples or user pattern on all lanes
// R4 - Sync pattern: user pattern, strobe on bus LSB, or strobe on all lanes
// R5 - User pattern is eight programmable samples output in order
// R6 - Pattern restarts every frame; truncated when short, repeats when long
// R7 - Per-bus inversion: A bit 8, B bit 9, C bit 10, D bit 11
// R8 - Fixed lane pattern control overrides the programmed user pattern
// R9 - Fixed lane pattern 000,FFF,000,000,000,FFF,FFF,FFF with same frame rules
// R10 - Power-down pin high disables all output data drivers
// R11 - Configuration mode bit also enters power-down
// R12 - Receiver re-establishes link and discards stale data after power-down
// R13 - During foreground calibration output data are forced to mid-code 000
// R14 - Calibration runs at power-up; host waits before programming registers
// R15 - Calibration starts from pin or software trigger, chosen by select bit
// R16 - Offset calibration runs once per calibration and writes the trim registers
// R17 - Host leaves trim registers alone and reads them after done flag
// R18 - Samples are twelve bits; inversion applied after selection, before driving
// R19 - Mid-frame changes of source, pattern or lane control wait for frame edge
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module ltp_top #(
	parameter int unsigned CAL_CYCLES = 2000
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [ltp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ltp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ltp_pkg::DATA_W-1:0] reg_rdata,
	input wire ltp_pkg::ltp_quad_t adc_samples,
	input wire logic frame_strobe,
	input wire logic sync_select_pin,
	input wire logic power_down_pin,
	input wire logic calibration_trigger_pin,
	input wire logic [11:0] offset_result_in_phase,
	input wire logic [11:0] offset_result_quadrature,
	output ltp_pkg::ltp_out_s lvds_out,
	output logic driver_enable,
	output logic converters_offline,
	output logic irq
);
	// Counter must hold the duration and the busy-window assertion needs eight cycles
	if (CAL_CYCLES < 8 || CAL_CYCLES >= (1 << ltp_pkg::CNT_W)) begin : g_cal_range
		$error("CAL_CYCLES out of range");
	end

	// Last count of the busy window, cut to the counter width on purpose
	localparam int unsigned CAL_LAST_I = CAL_CYCLES - 1;
	localparam logic [ltp_pkg::CNT_W-1:0] CAL_LAST = CAL_LAST_I[ltp_pkg::CNT_W-1:0];

	logic link_src_reg;
	logic link_swsel_reg;
	logic act_user_reg;
	logic [1:0] sync_pattern_select_reg;
	logic [3:0] inv_reg;
	logic fixed_lane_pattern_enable_reg;
	logic mode_pd_reg;
	logic offset_calibration_enable_reg;
	logic cal_src_reg;
	logic [11:0] upat_reg [ltp_pkg::PAT_LEN];
	logic [11:0] trim_i_reg;
	logic [11:0] trim_q_reg;
	logic [1:0] irq_stat_reg;
	logic [1:0] irq_mask_reg;
	logic [ltp_pkg::DATA_W-1:0] rdata_reg;
	logic [ltp_pkg::DATA_W-1:0] rdata_next;
	logic strobe_d_reg;
	logic cal_pin_d_reg;
	logic pd_d_reg;
	logic in_sync_reg;
	ltp_pkg::ltp_frame_cfg_s cfg_reg;
	logic [ltp_pkg::IDX_W-1:0] idx_reg;
	logic cal_busy_reg;
	logic cal_done_reg;
	logic [ltp_pkg::CNT_W-1:0] cal_cnt_reg;
	ltp_pkg::ltp_out_s out_reg;
	ltp_pkg::ltp_out_s out_next;
	logic drv_en_reg;

	// Address decode
	wire logic wr_link = reg_wr && reg_addr == ltp_pkg::ADDR_LINK_CTRL;
	wire logic wr_pat = reg_wr && reg_addr == ltp_pkg::ADDR_PATTERN_SELECT_REG;
	wire logic wr_upc = reg_wr && reg_addr == ltp_pkg::ADDR_USER_PATTERN_CONTROL_REG;
	wire logic wr_cfg = reg_wr && reg_addr == ltp_pkg::ADDR_DEV_CFG;
	wire logic wr_calcfg = reg_wr && reg_addr == ltp_pkg::ADDR_CAL_CFG;
	wire logic wr_trig = reg_wr && reg_addr == ltp_pkg::ADDR_CALIBRATION_TRIGGER_PIN;
	wire logic wr_trim_i = reg_wr && reg_addr == ltp_pkg::ADDR_TRIM_I;
	wire logic wr_trim_q = reg_wr && reg_addr == ltp_pkg::ADDR_TRIM_Q;
	wire logic wr_istat = reg_wr && reg_addr == ltp_pkg::ADDR_IRQ_STAT;
	wire logic wr_imask = reg_wr && reg_addr == ltp_pkg::ADDR_IRQ_MASK;
	wire logic upat_hit = reg_addr >= ltp_pkg::ADDR_UPAT_BASE
		&& reg_addr <= ltp_pkg::ADDR_UPAT_LAST && reg_addr[1:0] == 2'h0;
	wire logic [ltp_pkg::IDX_W-1:0] upat_sel = reg_addr[ltp_pkg::IDX_W+1:2];

	// Frame boundary and the pattern toggle source
	wire logic frame_fall = strobe_d_reg && !frame_strobe; // R2
	wire logic sync_req = link_src_reg ? link_swsel_reg : sync_select_pin; // R1
	wire logic [ltp_pkg::IDX_W-1:0] eff_idx = frame_fall ? '0 : idx_reg; // R6
	wire ltp_pkg::ltp_frame_cfg_s cfg_now = '{
		sync_from_reg: sync_req,
		act_user: act_user_reg,
		sync_pattern_select: ltp_pkg::ltp_sync_pattern_select_e'(sync_pattern_select_reg),
		fixed_lane_pattern_enable: fixed_lane_pattern_enable_reg
	};
	// Settings chosen at a frame edge hold for the whole frame
	wire ltp_pkg::ltp_frame_cfg_s cfg_eff = frame_fall ? cfg_now : cfg_reg; // R19
	wire logic sync_eff = frame_fall ? sync_req : in_sync_reg; // R2

	// Calibration trigger and power-down
	wire logic pin_rise = calibration_trigger_pin && !cal_pin_d_reg;
	wire logic cal_trigger = cal_src_reg ? (wr_trig && reg_wdata[0]) : pin_rise; // R15
	wire logic cal_start = cal_trigger && !cal_busy_reg;
	wire logic cal_end = cal_busy_reg && cal_cnt_reg == CAL_LAST;
	wire logic pd_now = power_down_pin || mode_pd_reg; // R10 R11
	wire logic pd_exit = pd_d_reg && !pd_now;

	// Pattern word: fixed lane pattern wins over the user registers
	wire logic [11:0] upat_word = upat_reg[eff_idx]; // R5
	wire logic [11:0] lane_word = {12{ltp_pkg::FIXED_LANE_PATTERN_ENABLE_MASK[eff_idx]}}; // R9
	wire logic [11:0] pat_word = cfg_eff.fixed_lane_pattern_enable ? lane_word : upat_word; // R8
	wire logic pat_path = sync_eff ? cfg_eff.sync_pattern_select == ltp_pkg::LTP_SYNC_USER
		: cfg_eff.act_user;

	// Per-bus selection; inversion only touches the selected pattern word
	wire ltp_pkg::ltp_quad_t data_next;
	generate
		for (genvar b = 0; b < ltp_pkg::BUSES; b++) begin : g_bus
			wire logic [11:0] inv_mask = {11'h000, inv_reg[b]} << (8 + b); // R7
			wire logic [11:0] pat_inv = pat_word ^ inv_mask; // R18
			wire logic [11:0] smp = adc_samples[b];
			// Each bus owns its word so no two processes write one variable
			logic [11:0] bus_word;
			always_comb begin
				if (cal_busy_reg) begin
					bus_word = ltp_pkg::MID_CODE; // R13
				end else if (!sync_eff) begin
					bus_word = cfg_eff.act_user ? pat_inv : smp; // R3
				end else begin
					unique case (cfg_eff.sync_pattern_select) // R4
						ltp_pkg::LTP_SYNC_USER: bus_word = pat_inv;
						ltp_pkg::LTP_SYNC_STROBE_LSB: bus_word = {smp[11:1], frame_strobe};
						ltp_pkg::LTP_SYNC_STROBE_ALL: bus_word = {12{frame_strobe}};
						ltp_pkg::LTP_SYNC_SPARE: bus_word = {12{frame_strobe}};
					endcase
				end
			end
			assign data_next[b] = bus_word;
		end
	endgenerate
	assign out_next = '{data: data_next, strobe: frame_strobe};

	// Control registers written by software
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			link_src_reg <= 1'b0;
			link_swsel_reg <= 1'b0;
			act_user_reg <= 1'b0;
			sync_pattern_select_reg <= 2'h0;
			inv_reg <= 4'h0;
			fixed_lane_pattern_enable_reg <= 1'b0;
			mode_pd_reg <= 1'b0;
			offset_calibration_enable_reg <= 1'b0;
			cal_src_reg <= 1'b0;
			irq_mask_reg <= 2'h0;
		end else begin
			if (wr_link) begin
				link_src_reg <= reg_wdata[ltp_pkg::LINK_SRC_BIT];
				link_swsel_reg <= reg_wdata[ltp_pkg::LINK_SWSEL_BIT];
			end
			if (wr_pat) begin
				act_user_reg <= reg_wdata[ltp_pkg::PAT_ACT_BIT];
				sync_pattern_select_reg <= reg_wdata[ltp_pkg::PAT_SYNC_LO+:2];
			end
			if (wr_upc) begin
				inv_reg <= reg_wdata[3:0];
				fixed_lane_pattern_enable_reg <= reg_wdata[ltp_pkg::UPAT_LANE_BIT];
			end
			if (wr_cfg) begin
				mode_pd_reg <= reg_wdata[ltp_pkg::CFG_PD_BIT];
			end
			if (wr_calcfg) begin
				offset_calibration_enable_reg <= reg_wdata[ltp_pkg::OFFSET_CALIBRATION_ENABLE_BIT];
				cal_src_reg <= reg_wdata[ltp_pkg::CAL_SRC_BIT];
			end
			if (wr_imask) begin
				irq_mask_reg <= reg_wdata[1:0];
			end
		end
	end

	// User pattern storage; left unreset since software loads it before use
	always_ff @(posedge sys_clk) begin
		if (reg_wr && upat_hit) begin
			upat_reg[upat_sel] <= reg_wdata[11:0];
		end
	end

	// Trim registers: the offset calibration result overrides a same-cycle write
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			trim_i_reg <= ltp_pkg::TRIM_RESET;
			trim_q_reg <= ltp_pkg::TRIM_RESET;
		end else if (cal_end && offset_calibration_enable_reg) begin
			trim_i_reg <= offset_result_in_phase; // R16
			trim_q_reg <= offset_result_quadrature; // R16
		end else begin
			if (wr_trim_i) begin
				trim_i_reg <= reg_wdata[11:0];
			end
			if (wr_trim_q) begin
				trim_q_reg <= reg_wdata[11:0];
			end
		end
	end

	// Sticky events; a new event beats a same-cycle clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_stat_reg <= 2'h0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? reg_wdata[1:0] : 2'h0))
				| {pd_exit, cal_end};
		end
	end

	// Frame tracking: pattern index restarts on each frame edge and wraps at eight
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			strobe_d_reg <= 1'b0;
			idx_reg <= '0;
			in_sync_reg <= 1'b0;
			cfg_reg <= '0;
		end else begin
			strobe_d_reg <= frame_strobe;
			idx_reg <= eff_idx + 3'h1; // R6
			in_sync_reg <= sync_eff; // R2
			cfg_reg <= cfg_eff; // R19
		end
	end

	// Calibration sequencer; busy from reset so power-up always calibrates
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cal_busy_reg <= 1'b1; // R14
			cal_done_reg <= 1'b0;
			cal_cnt_reg <= '0;
			cal_pin_d_reg <= 1'b0;
		end else begin
			cal_pin_d_reg <= calibration_trigger_pin;
			if (cal_start) begin
				cal_busy_reg <= 1'b1; // R15
				cal_done_reg <= 1'b0;
				cal_cnt_reg <= '0;
			end else if (cal_end) begin
				cal_busy_reg <= 1'b0;
				cal_done_reg <= 1'b1;
			end else if (cal_busy_reg) begin
				cal_cnt_reg <= cal_cnt_reg + 16'h0001;
			end
		end
	end

	// Output stage; data zeroed while drivers are off to avoid stale codes on wake
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			out_reg <= '0;
			drv_en_reg <= 1'b0;
			pd_d_reg <= 1'b0;
		end else begin
			out_reg <= pd_now ? '0 : out_next;
			drv_en_reg <= !pd_now; // R10 R11
			pd_d_reg <= pd_now;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_next = '0;
		unique case (reg_addr)
			ltp_pkg::ADDR_LINK_CTRL: rdata_next[1:0] = {link_swsel_reg, link_src_reg};
			ltp_pkg::ADDR_PATTERN_SELECT_REG: rdata_next[3:0] = {sync_pattern_select_reg, 1'b0, act_user_reg};
			ltp_pkg::ADDR_USER_PATTERN_CONTROL_REG: rdata_next[4:0] = {fixed_lane_pattern_enable_reg, inv_reg};
			ltp_pkg::ADDR_DEV_CFG: rdata_next[0] = mode_pd_reg;
			ltp_pkg::ADDR_CAL_CFG: rdata_next[1:0] = {cal_src_reg, offset_calibration_enable_reg};
			ltp_pkg::ADDR_CAL_STAT: rdata_next[1:0] = {cal_busy_reg, cal_done_reg};
			ltp_pkg::ADDR_TRIM_I: rdata_next[11:0] = trim_i_reg;
			ltp_pkg::ADDR_TRIM_Q: rdata_next[11:0] = trim_q_reg;
			ltp_pkg::ADDR_IRQ_STAT: rdata_next[1:0] = irq_stat_reg;
			ltp_pkg::ADDR_IRQ_MASK: rdata_next[1:0] = irq_mask_reg;
			default: rdata_next[11:0] = upat_hit ? upat_reg[upat_sel] : 12'h000;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= reg_rd ? rdata_next : '0;
		end
	end

	assign reg_rdata = rdata_reg;
	assign lvds_out = out_reg;
	assign driver_enable = drv_en_reg;
	assign converters_offline = cal_busy_reg; // R13
	assign irq = |(irq_stat_reg & irq_mask_reg);

	// Checks
	sequence frame_edge_s;
		strobe_d_reg && !frame_strobe;
	endsequence

	sequence mid_frame_s;
		!(strobe_d_reg && !frame_strobe);
	endsequence

	src_pin_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
		frame_edge_s and (!link_src_reg) |=> in_sync_reg == $past(sync_select_pin))
		else $error("sync state did not follow pin at frame edge");

	sync_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R2
		mid_frame_s |=> $stable(in_sync_reg) && $stable(cfg_reg))
		else $error("pattern changed inside a frame");

	idx_restart_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
		frame_edge_s ##1 mid_frame_s |=> idx_reg == 3'h2)
		else $error("pattern index did not restart at frame edge");

	user_pat_a: assert property (@(posedge sys_clk) disable iff (rst) // R5
		pat_path && !cfg_eff.fixed_lane_pattern_enable && !cal_busy_reg && !pd_now
		|=> lvds_out.data[2][7:0] == $past(upat_word[7:0]))
		else $error("user pattern word not driven");

	fixed_lane_pattern_enable_a: assert property (@(posedge sys_clk) disable iff (rst) // R9
		pat_path && cfg_eff.fixed_lane_pattern_enable && !cal_busy_reg && !pd_now && eff_idx == 3'h5
		|=> lvds_out.data[0][7:0] == 8'hFF)
		else $error("fixed lane pattern wrong at sample five");

	invert_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
		pat_path && !cal_busy_reg && !pd_now
		|=> (lvds_out.data[0][8] ^ lvds_out.data[1][8]) == $past(inv_reg[0]))
		else $error("bus A bit 8 inversion wrong");

	strobe_lsb_a: assert property (@(posedge sys_clk) disable iff (rst) // R4
		sync_eff && cfg_eff.sync_pattern_select == ltp_pkg::LTP_SYNC_STROBE_LSB && !cal_busy_reg && !pd_now
		|=> lvds_out.data[3][0] == $past(frame_strobe)
			&& lvds_out.data[3][11:1] == $past(adc_samples[3][11:1]))
		else $error("strobe not on bus LSB");

	pd_drv_a: assert property (@(posedge sys_clk) disable iff (rst) // R10
		power_down_pin |=> !driver_enable && lvds_out.data == '0)
		else $error("drivers active during power-down");

	cal_mid_a: assert property (@(posedge sys_clk) disable iff (rst) // R13
		cal_busy_reg && !pd_now |=> lvds_out.data == '0)
		else $error("output not mid-code during calibration");

	cal_start_a: assert property (@(posedge sys_clk) disable iff (rst) // R15
		cal_start |=> cal_busy_reg [*7] ##1 !cal_done_reg)
		else $error("calibration did not start on trigger");

	trim_load_a: assert property (@(posedge sys_clk) disable iff (rst) // R16
		cal_end && offset_calibration_enable_reg |=> trim_i_reg == $past(offset_result_in_phase)
			&& cal_done_reg && !cal_busy_reg)
		else $error("offset trim not loaded at calibration end");

	src_reg_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
		frame_edge_s and (link_src_reg) |=> in_sync_reg == $past(link_swsel_reg))
		else $error("sync state did not follow register at frame edge");

	idx_wrap_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
		mid_frame_s and (idx_reg == 3'h7) |=> idx_reg == 3'h0)
		else $error("pattern index did not wrap after eighth sample");

	mode_pd_a: assert property (@(posedge sys_clk) disable iff (rst) // R11
		mode_pd_reg |=> !driver_enable && lvds_out.data == '0)
		else $error("drivers active during mode power-down");
endmodule : ltp_top

//--- ltp_rx_model.sv
// Receiver capture model that drops stale words after the output drivers come back
`timescale 1ns/1ps
module ltp_rx_model #(
	parameter int FLUSH = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire ltp_pkg::ltp_out_s lvds_out,
	input wire logic driver_enable,
	output logic link_valid,
	output ltp_pkg::ltp_quad_t rx_data
);
	logic [7:0] flush_reg;
	ltp_pkg::ltp_quad_t held_reg;

	// Pipeline words stay untrusted until the flush count has run out
	always_ff @(posedge sys_clk) begin
		if (rst || !driver_enable) begin
			flush_reg <= 8'h00;
		end else if (flush_reg < 8'(FLUSH)) begin
			flush_reg <= flush_reg + 8'h01;
		end
	end
	assign link_valid = (flush_reg == 8'(FLUSH));

	// Released drivers carry nothing; show the inverse of the last good word
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			held_reg <= '0;
			rx_data <= '0;
		end else if (driver_enable) begin
			held_reg <= lvds_out.data;
			rx_data <= lvds_out.data;
		end else begin
			rx_data <= ~held_reg;
		end
	end
endmodule : ltp_rx_model

//--- ltp_top_bench.sv
// Self-checking bench for the pattern source, power-down and calibration block
`timescale 1ns/1ps
module ltp_top_bench;
	localparam logic [7:0] LANE_SEQ = 8'hE2;
	logic sys_clk, rst, reg_wr, reg_rd, fs, sync_pin, pd_pin, cal_pin;
	logic drv_en, offline, irq, link_valid;
	logic [11:0] os_i, os_q;
	ltp_pkg::ltp_quad_t rx_data;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	ltp_pkg::ltp_quad_t adc;
	ltp_pkg::ltp_out_s lvds_out;
	logic [11:0] upat [8];
	logic [3:0] inv;
	int mode, err_count, n_tests;

	ltp_top #(.CAL_CYCLES(16)) u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.adc_samples(adc), .frame_strobe(fs), .sync_select_pin(sync_pin),
		.power_down_pin(pd_pin), .calibration_trigger_pin(cal_pin),
		.offset_result_in_phase(os_i), .offset_result_quadrature(os_q),
		.lvds_out(lvds_out), .driver_enable(drv_en), .converters_offline(offline), .irq(irq));
	ltp_rx_model u_rx (.sys_clk(sys_clk), .rst(rst), .lvds_out(lvds_out),
		.driver_enable(drv_en), .link_valid(link_valid), .rx_data(rx_data));

	// Clock at 100 MHz
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Expected word of one bus for the current mode
	function automatic logic [11:0] expv(input int b, input int k, input logic s);
		case (mode)
			0: return adc[b];
			1: return upat[k % 8] ^ ((12'h100 << b) & {12{inv[b]}});
			2: return {12{LANE_SEQ[k % 8]}};
			3: return {adc[b][11:1], s};
			4: return {12{s}};
			default: return 12'h000;
		endcase
	endfunction : expv

	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd

	task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
		logic [15:0] v;
		rd(a, v);
		chk(nm, e, v);
	endtask : rchk

	// Poll the status word with a bounded count
	task automatic wait_done;
		int n;
		n = 0;
		d = 16'h0000;
		while (d[0] !== 1'b1 && n < 60) begin
			rd(ltp_pkg::ADDR_CAL_STAT, d);
			n++;
		end
		chk("cal status", 16'h0001, d);
	endtask : wait_done

	// One frame: strobe falls, then len samples checked; optional register write in mid-frame
	task automatic frame(input int len, input logic [7:0] ma, input logic [15:0] md, input logic mw);
		@(posedge sys_clk) fs <= 1'b0;
		for (int k = 0; k < len; k++) begin
			@(posedge sys_clk);
			if (k == len - 2) fs <= 1'b1;
			reg_wr <= mw && (k == 0);
			reg_addr <= ma;
			reg_wdata <= md;
			#1;
			chk("strobe", 48'(k == len - 1), 48'(lvds_out.strobe));
			for (int b = 0; b < 4; b++) begin
				chk("bus data", 48'(expv(b, k, k == len - 1)), 48'(lvds_out.data[b]));
			end
		end
	endtask : frame

	task automatic pin_cal(input logic e);
		@(posedge sys_clk) cal_pin <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk("offline after pin", 48'(e), 48'(offline));
		@(posedge sys_clk) cal_pin <= 1'b0;
	endtask : pin_cal

	task complete_run;
		$display("Checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	// Watchdog far beyond the expected run of about 250 cycles
	initial begin
		#100000;
		err_count++;
		complete_run();
	end

	// Main sequence
	initial begin
		{rst, fs} = 2'b11;
		{reg_wr, reg_rd, sync_pin, pd_pin, cal_pin} = 5'h00;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		adc = {12'hD4B, 12'h96C, 12'h5A1, 12'h2E7};
		{os_i, os_q} = {12'h5A3, 12'hA5C};
		err_count = 0;
		n_tests = 0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("offline at power-up", 48'h1, 48'(offline));
		chk("mid-code at power-up", 48'h0, 48'(lvds_out.data));
		wait_done();
		rchk("unmapped read", 8'hFC, 16'h0000);
		rchk("irq status", ltp_pkg::ADDR_IRQ_STAT, 16'h0001);
		chk("irq masked", 48'h0, 48'(irq));
		wr(ltp_pkg::ADDR_IRQ_MASK, 16'h0001);
		chk("irq unmasked", 48'h1, 48'(irq));
		wr(ltp_pkg::ADDR_IRQ_STAT, 16'h0001);
		chk("irq cleared", 48'h0, 48'(irq));
		for (int k = 0; k < 8; k++) begin
			upat[k] = {4'(k + 1), 8'hC3 ^ 8'(k)};
			wr(ltp_pkg::ADDR_UPAT_BASE + 8'(4 * k), 16'(upat[k]));
		end
		rchk("user word last", ltp_pkg::ADDR_UPAT_LAST, 16'(upat[7]));
		inv = 4'b0101;
		wr(ltp_pkg::ADDR_USER_PATTERN_CONTROL_REG, 16'h0005);
		mode = 0;
		frame(4, ltp_pkg::ADDR_PATTERN_SELECT_REG, 16'h0001, 1'b1);
		mode = 1;
		frame(10, 8'h00, 16'h0000, 1'b0);
		frame(5, 8'h00, 16'h0000, 1'b0);
		frame(3, 8'h00, 16'h0000, 1'b0);
		inv = 4'b0000;
		wr(ltp_pkg::ADDR_USER_PATTERN_CONTROL_REG, 16'h0010);
		mode = 2;
		frame(9, 8'h00, 16'h0000, 1'b0);
		inv = 4'b1010;
		wr(ltp_pkg::ADDR_USER_PATTERN_CONTROL_REG, 16'h000A);
		@(posedge sys_clk) sync_pin <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			wr(ltp_pkg::ADDR_PATTERN_SELECT_REG, 16'((c << 2) | 1));
			mode = (c == 0) ? 1 : c + 2 - (c == 3);
			frame(4, 8'h00, 16'h0000, 1'b0);
		end
		rchk("pattern select", ltp_pkg::ADDR_PATTERN_SELECT_REG, 16'h000D);
		frame(4, ltp_pkg::ADDR_LINK_CTRL, 16'h0001, 1'b1);
		mode = 1;
		frame(3, 8'h00, 16'h0000, 1'b0);
		wr(ltp_pkg::ADDR_LINK_CTRL, 16'h0003);
		mode = 4;
		frame(3, 8'h00, 16'h0000, 1'b0);
		rchk("link control", ltp_pkg::ADDR_LINK_CTRL, 16'h0003);
		rchk("user pattern control", ltp_pkg::ADDR_USER_PATTERN_CONTROL_REG, 16'h000A);
		@(posedge sys_clk) pd_pin <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("drivers off by pin", 48'h0, 48'(drv_en));
		chk("data in power-down", 48'h0, 48'(lvds_out.data));
		@(posedge sys_clk) pd_pin <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("drivers back", 48'h1, 48'(drv_en));
		chk("link stale", 48'h0, 48'(link_valid));
		repeat (10) @(posedge sys_clk);
		#1;
		chk("link flushed", 48'h1, 48'(link_valid));
		chk("rx capture", 48'hFFFF_FFFF_FFFF, 48'(rx_data));
		rchk("irq exit status", ltp_pkg::ADDR_IRQ_STAT, 16'h0002);
		chk("irq exit masked", 48'h0, 48'(irq));
		wr(ltp_pkg::ADDR_IRQ_STAT, 16'h0002);
		wr(ltp_pkg::ADDR_DEV_CFG, 16'h0001);
		@(posedge sys_clk);
		#1;
		chk("drivers off by mode", 48'h0, 48'(drv_en));
		rchk("power-down mode", ltp_pkg::ADDR_DEV_CFG, 16'h0001);
		wr(ltp_pkg::ADDR_DEV_CFG, 16'h0000);
		wr(ltp_pkg::ADDR_CAL_CFG, 16'h0003);
		rchk("cal config", ltp_pkg::ADDR_CAL_CFG, 16'h0003);
		pin_cal(1'b0);
		wr(ltp_pkg::ADDR_CALIBRATION_TRIGGER_PIN, 16'h0001);
		@(posedge sys_clk);
		#1;
		chk("offline on soft trigger", 48'h1, 48'(offline));
		chk("mid-code in cal", 48'h0, 48'(lvds_out.data));
		rchk("busy status", ltp_pkg::ADDR_CAL_STAT, 16'h0002);
		wait_done();
		rchk("trim in-phase", ltp_pkg::ADDR_TRIM_I, 16'h05A3);
		rchk("trim quadrature", ltp_pkg::ADDR_TRIM_Q, 16'h0A5C);
		chk("irq cal done", 48'h1, 48'(irq));
		wr(ltp_pkg::ADDR_IRQ_STAT, 16'h0001);
		chk("irq cal cleared", 48'h0, 48'(irq));
		wr(ltp_pkg::ADDR_CAL_CFG, 16'h0000);
		@(posedge sys_clk) os_i <= 12'h3C7;
		pin_cal(1'b1);
		wait_done();
		rchk("trim kept", ltp_pkg::ADDR_TRIM_I, 16'h05A3);
		wr(ltp_pkg::ADDR_TRIM_I, 16'h0123);
		rchk("trim written", ltp_pkg::ADDR_TRIM_I, 16'h0123);
		complete_run();
	end
endmodule : ltp_top_bench
